// File: hw/line_write_pkg.sv
// Purpose: Shared constants for the four long-word line write sequencer.
// Assumes: One bus clock; synchronous active-low reset.
// Notes: Rule summary follows.
// What this block does
// - Start clock asserts start and cycle-in-progress.
// - Next clock negates start, drives first word.
// - Sample ack and inhibit; wait until ack.
// - Inhibit negated with first ack: continue burst.
// - Inhibit asserted: three long-word cycles, index incremented.
// - No waits: inhibited eight clocks, burst five.
// - Burst beats hold address and attributes steady.
// - Each later beat waits for ack.
// - Fourth and fifth clocks drive third, fourth words.
// - After last ack, cycle-in-progress holds only if ready.
// - Clock after termination releases the data bus.
package line_write_pkg;
   // ==========================================================
   // Widths and depths
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned ADDR_W     = 32;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned LINE_WORDS = 4;
   // ==========================================================
   // Address field position of the long-word index
   localparam int unsigned IDX_LO = 2;
   localparam int unsigned IDX_HI = 3;
   // ==========================================================
   // Size codes and direction
   localparam logic [1:0] SIZE_LINE = 2'h3;
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic       RW_WRITE  = 1'h0;
   // ==========================================================
   // Clock counts of a line with no wait states
   localparam logic [3:0] BURST_CLKS   = 4'h5;
   localparam logic [3:0] INHIBIT_CLKS = 4'h8;
   localparam logic [1:0] LAST_BEAT    = 2'h3;
   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h00000000;
   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {IDLE, START, DATA} seq_state_t;
endpackage

// File: hw/word_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides and a fill count.
// Assumes: Depth is a power of two.
// Notes: Full and empty come from pointers with one extra wrap bit.
`timescale 1ns/1ps
module word_fifo #(
   parameter int unsigned WIDTH = line_write_pkg::DATA_W,
   parameter int unsigned DEPTH = line_write_pkg::FIFO_DEPTH
) (
   input  wire logic                     core_clk,
   input  wire logic                     reset_n,
   input  wire logic [WIDTH-1:0]         inData,
   input  wire logic                     inValid,
   output logic                          inReady,
   output logic [WIDTH-1:0]              outData,
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [$clog2(DEPTH):0]        fillCount
);
   localparam int unsigned AW         = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] PTR_STEP   = (AW+1)'(1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wrPtr_q;
   logic [AW:0]      rdPtr_q;
   logic             pushEn;
   logic             popEn;
   // ==========================================================
   // Status decode
   assign pushEn    = inValid && inReady;
   assign popEn     = outValid && outReady;
   assign fillCount = wrPtr_q - rdPtr_q;
   assign inReady   = (fillCount != FULL_COUNT);
   assign outValid  = (fillCount != '0);
   assign outData   = mem_q[rdPtr_q[AW-1:0]];
   // Pointer update
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (pushEn) wrPtr_q <= wrPtr_q + PTR_STEP;
         if (popEn)  rdPtr_q <= rdPtr_q + PTR_STEP;
      end
   end
   // Storage, one entry per slot
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge core_clk) begin
         if (pushEn && wrPtr_q[AW-1:0] == AW'(i)) mem_q[i] <= inData;
      end
   end
endmodule // word_fifo

// File: hw/line_write_bus_cycle.sv
// Purpose: Processor-side sequencer for a four long-word line write.
// Assumes: Bus inputs synchronous to core_clk; FIFO supplies line data.
// Notes: A line starts only with four words buffered, so beats never starve.
`timescale 1ns/1ps
module line_write_bus_cycle (
   input  wire logic                              core_clk,
   input  wire logic                              reset_n,
   input  wire logic [line_write_pkg::DATA_W-1:0] wordData,
   input  wire logic                              wordValid,
   output logic                                   wordReady,
   input  wire logic [line_write_pkg::ADDR_W-1:0] lineAddr,
   input  wire logic                              lineValid,
   output logic                                   lineReady,
   output logic [line_write_pkg::ADDR_W-1:0]      busAddr,
   output logic [line_write_pkg::DATA_W-1:0]      busDataOut,
   output logic                                   busDataOe,
   output logic                                   readWrite,
   output logic                                   sizeCodeHi,
   output logic                                   sizeCodeLo,
   output logic                                   transferStartN,
   output logic                                   cycleInProgressN,
   input  wire logic                              transferAckN,
   input  wire logic                              burstInhibitN
);
   // ==========================================================
   // Local widths
   localparam int unsigned       FILL_W    = $clog2(line_write_pkg::FIFO_DEPTH) + 1;
   localparam logic [FILL_W-1:0] LINE_FILL = FILL_W'(line_write_pkg::LINE_WORDS);

   // ==========================================================
   // Sequencer state and registered bus outputs
   line_write_pkg::seq_state_t        state_q;
   line_write_pkg::seq_state_t        state_d;
   logic [1:0]                        beat_q;
   logic [1:0]                        beat_d;
   logic                              inhibit_q;
   logic                              inhibit_d;
   logic [line_write_pkg::ADDR_W-1:0] busAddr_q;
   logic [line_write_pkg::ADDR_W-1:0] busAddr_d;
   logic [line_write_pkg::ADDR_W-1:0] stepAddr;
   logic [line_write_pkg::DATA_W-1:0] busData_q;
   logic [line_write_pkg::DATA_W-1:0] busData_d;
   logic [1:0]                        size_q;
   logic [1:0]                        size_d;
   logic                              busOe_q;
   logic                              startN_q;
   logic                              tipN_q;
   logic                              readWrite_q;

   // ==========================================================
   // Line buffer side
   logic [line_write_pkg::DATA_W-1:0] fifoData;
   logic                              fifoValid;
   logic [FILL_W-1:0]                 fifoFill;
   logic                              loadWord;

   // ==========================================================
   // Decode wires
   logic                              inIdle;
   logic                              inStart;
   logic                              inDataPhase;
   logic                              ackSeen;
   logic                              lastBeat;
   logic                              firstBeat;
   logic                              stepLong;
   logic                              longNext;
   logic                              burstNext;
   logic                              fillEnough;
   logic                              lineLaunch;
   logic                              idleNext;
   logic                              startNext;
   logic                              dataNext;

   // ==========================================================
   // Word buffer
   // Words wait here until a whole line is present, so beats never starve
   word_fifo #(
      .WIDTH     (line_write_pkg::DATA_W),
      .DEPTH     (line_write_pkg::FIFO_DEPTH)
   ) lineFifo (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .inData    (wordData),
      .inValid   (wordValid),
      .inReady   (wordReady),
      .outData   (fifoData),
      .outValid  (fifoValid),
      .outReady  (loadWord),
      .fillCount (fifoFill)
   );

   // ==========================================================
   // State decode
   // Where the sequencer stands and what the slave answered this clock
   assign inIdle      = (state_q == line_write_pkg::IDLE);
   assign inStart     = (state_q == line_write_pkg::START);
   assign inDataPhase = (state_q == line_write_pkg::DATA);
   assign ackSeen     = inDataPhase && !transferAckN;
   assign lastBeat    = (beat_q == line_write_pkg::LAST_BEAT);
   assign firstBeat   = (beat_q == 2'h0);

   // Inhibit counts only with the first ack; later levels are ignored
   assign stepLong    = firstBeat ? !burstInhibitN : inhibit_q;
   assign longNext    = ackSeen && !lastBeat && stepLong;
   assign burstNext   = ackSeen && !lastBeat && !stepLong;

   // A line may start from idle, or straight after the last ack of the one before
   assign fillEnough  = (fifoFill >= LINE_FILL);
   assign lineLaunch  = lineValid && fillEnough && (inIdle || (ackSeen && lastBeat));
   assign lineReady   = lineLaunch;

   // One word leaves the buffer per beat, in ascending index order
   assign loadWord    = inStart || burstNext;

   // ==========================================================
   // Next state
   // Burst: one start clock and four data clocks; inhibited: two clocks per word
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         line_write_pkg::IDLE: begin
            if (lineLaunch) begin
               state_d = line_write_pkg::START;
            end
         end
         line_write_pkg::START: begin
            state_d = line_write_pkg::DATA;
         end
         line_write_pkg::DATA: begin
            if (ackSeen && lastBeat) begin
               state_d = lineLaunch ? line_write_pkg::START : line_write_pkg::IDLE;
            end else if (longNext) begin
               state_d = line_write_pkg::START;
            end
         end
         default: begin
            state_d = line_write_pkg::IDLE;
         end
      endcase
   end

   // ==========================================================
   // Next register values
   // Strobe levels follow from the state being entered
   assign idleNext  = (state_d == line_write_pkg::IDLE);
   assign startNext = (state_d == line_write_pkg::START);
   assign dataNext  = (state_d == line_write_pkg::DATA);

   // Beat index and the inhibit answer latched with the first ack
   assign beat_d    = lineLaunch ? 2'h0 :
                      (ackSeen && !lastBeat) ? beat_q + 2'h1 : beat_q;
   assign inhibit_d = lineLaunch ? 1'h0 :
                      (ackSeen && firstBeat) ? !burstInhibitN : inhibit_q;

   // Only a separate long-word cycle moves the index bits
   assign stepAddr  = {busAddr_q[line_write_pkg::ADDR_W-1:line_write_pkg::IDX_HI+1],
                       busAddr_q[line_write_pkg::IDX_HI:line_write_pkg::IDX_LO] + 2'h1,
                       busAddr_q[line_write_pkg::IDX_LO-1:0]};
   assign busAddr_d = lineLaunch ? lineAddr :
                      longNext ? stepAddr : busAddr_q;
   assign size_d    = lineLaunch ? line_write_pkg::SIZE_LINE :
                      longNext ? line_write_pkg::SIZE_LONG : size_q;
   assign busData_d = loadWord ? fifoData : busData_q;

   // ==========================================================
   // Registers
   // State, beat index and inhibit flag
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_q   <= line_write_pkg::IDLE;
         beat_q    <= 2'h0;
         inhibit_q <= 1'h0;
      end else begin
         state_q   <= state_d;
         beat_q    <= beat_d;
         inhibit_q <= inhibit_d;
      end
   end

   // Address, size code and write data
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         busAddr_q <= line_write_pkg::ADDR_RST;
         size_q    <= line_write_pkg::SIZE_LINE;
         busData_q <= line_write_pkg::DATA_RST;
      end else begin
         busAddr_q <= busAddr_d;
         size_q    <= size_d;
         busData_q <= busData_d;
      end
   end

   // Strobes, cycle-in-progress and data bus enable
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         startN_q    <= 1'h1;
         tipN_q      <= 1'h1;
         busOe_q     <= 1'h0;
         readWrite_q <= 1'h1;
      end else begin
         startN_q    <= !startNext;
         tipN_q      <= idleNext;
         busOe_q     <= dataNext;
         readWrite_q <= idleNext ? 1'h1 : line_write_pkg::RW_WRITE;
      end
   end

   // ==========================================================
   // Outputs
   // Every bus output comes straight from a flip-flop
   assign busAddr          = busAddr_q;
   assign busDataOut       = busData_q;
   assign busDataOe        = busOe_q;
   assign readWrite        = readWrite_q;
   assign sizeCodeHi       = size_q[1];
   assign sizeCodeLo       = size_q[0];
   assign transferStartN   = startN_q;
   assign cycleInProgressN = tipN_q;

   // ==========================================================
   // Assertions
   // A start strobe always comes with cycle-in-progress
   start_tip_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !transferStartN |-> !cycleInProgressN
   ) else $error("start strobe without cycle in progress");

   // Start lasts one clock and data is driven in the next
   start_once_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !transferStartN |=> transferStartN && busDataOe
   ) else $error("start strobe not followed by a data clock");

   // Wait states hold data and address
   wait_hold_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      busDataOe && transferAckN |=> busDataOe && $stable(busDataOut) && $stable(busAddr)
   ) else $error("data phase changed during a wait state");

   // Burst beats keep address and attributes constant
   burst_hold_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      burstNext |=> busDataOe && $stable(busAddr) && $stable({sizeCodeHi, sizeCodeLo})
   ) else $error("address or attributes moved inside a burst");

   // An inhibited line steps the index for each new cycle
   long_step_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      longNext |=> !transferStartN &&
         (busAddr[line_write_pkg::IDX_HI:line_write_pkg::IDX_LO] ==
          $past(busAddr[line_write_pkg::IDX_HI:line_write_pkg::IDX_LO]) + 2'h1)
   ) else $error("separate long-word cycle without index step");

   // The data bus is let go after the last ack
   bus_release_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ackSeen && lastBeat |=> !busDataOe
   ) else $error("data bus still driven after the last ack");

   // Cycle-in-progress ends unless another line follows at once
   tip_end_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ackSeen && lastBeat && !lineLaunch |=> cycleInProgressN
   ) else $error("cycle in progress held with no line pending");

   // Every word taken from the buffer is a real one
   pop_valid_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      loadWord |-> fifoValid
   ) else $error("word taken from an empty buffer");
endmodule // line_write_bus_cycle


// File: testbench/line_slave_model.sv
// Purpose: Slave model for line writes.
// Assumes: Data phase while data driven, start negated.
// Notes: Acks each beat after waits clocks.
`timescale 1ns/1ps
module line_slave_model (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       dataPhase,
   input  wire logic       inhibit,
   input  wire logic [1:0] waits,
   output logic            transferAckN,
   output logic            burstInhibitN
);
   // Wait count per beat
   logic [1:0] waitCount_q;
   always_ff @(posedge core_clk) begin
      waitCount_q <= (!reset_n || !dataPhase || !transferAckN) ? 2'h0 : waitCount_q + 2'h1;
   end
   assign transferAckN  = !(dataPhase && waitCount_q == waits);
   assign burstInhibitN = !inhibit;
endmodule // line_slave_model

// File: testbench/tb.sv
// Purpose: Line write bench.
// Assumes: Slave model answers each beat.
// Notes: Four words per line.
`timescale 1ns/1ps
module tb;
   logic core_clk, reset_n, wordValid, lineValid, inhibit, wordReady, lineReady;
   logic busDataOe, transferStartN, cycleInProgressN, transferAckN, burstInhibitN;
   logic readWrite, sizeCodeHi, sizeCodeLo;
   logic [1:0]  waits;
   logic [31:0] wordData, busAddr, busDataOut;
   int          numErrors, comparisons, k, n;
   line_write_bus_cycle DUT (.core_clk, .reset_n, .wordData, .wordValid, .wordReady,
      .lineAddr(32'h00000100), .lineValid, .lineReady, .busAddr, .busDataOut, .busDataOe,
      .readWrite, .sizeCodeHi, .sizeCodeLo, .transferStartN, .cycleInProgressN,
      .transferAckN, .burstInhibitN);
   line_slave_model slave (.core_clk, .reset_n, .dataPhase(busDataOe && transferStartN),
      .inhibit, .waits, .transferAckN, .burstInhibitN);
   task check(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task stop_test;
      $display("errors %0d comparisons %0d", numErrors, comparisons);
      if (numErrors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Load four words, start a line, check each acked beat at the falling edge
   task run_line(logic inh, logic [1:0] w, logic [31:0] clks);
      logic [31:0] cyc;
      logic [1:0]  sizeExp;
      logic        launched;
      @(posedge core_clk);
      inhibit <= inh;
      waits <= w;
      for (k = 0; k < 4; k++) begin
         @(posedge core_clk);
         wordData <= 32'h000000A0 + k;
         wordValid <= 1'h1;
      end
      @(negedge core_clk);
      check("wordReady", wordReady, 1);
      @(posedge core_clk);
      wordValid <= 1'h0;
      lineValid <= 1'h1;
      k = 0;
      n = 0;
      cyc = 0;
      launched = 0;
      while (k < 4 && n++ < 80) begin
         @(negedge core_clk);
         cyc += (cycleInProgressN === 1'h0);
         if (lineReady === 1'h1) begin
            launched = 1;
            @(posedge core_clk);
            lineValid <= 1'h0;
         end else if (transferAckN === 1'h0 && busDataOe === 1'h1 && transferStartN === 1'h1) begin
            sizeExp = (inh && k > 0) ? line_write_pkg::SIZE_LONG : line_write_pkg::SIZE_LINE;
            check("data", busDataOut, 32'h000000A0 + k);
            check("addr", busAddr, inh ? 32'h00000100 + 4 * k : 32'h00000100);
            check("size", {sizeCodeHi, sizeCodeLo}, sizeExp);
            check("rw", readWrite, line_write_pkg::RW_WRITE);
            k++;
         end
      end
      check("launch", launched, 1);
      check("beats", k, 4);
      check("clocks", cyc, clks);
      @(negedge core_clk);
      check("oe", busDataOe, 0);
      check("tip", cycleInProgressN, 1);
   endtask
   task burst_plain; run_line(0, 0, 5); endtask
   task inhibit_plain; run_line(1, 0, 8); endtask
   task burst_waits; run_line(0, 2, 13); endtask
   task inhibit_waits; run_line(1, 1, 12); endtask
   initial begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      {reset_n, wordValid, lineValid, inhibit, waits, wordData} = '0;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'h1;
      burst_plain;
      inhibit_plain;
      burst_waits;
      inhibit_waits;
      stop_test;
   end
endmodule // tb
